/* File: cpu_move_mul_stack_ops.sv */
// decode and execute for moves, multiply, negate and return-stack instructions
// assumes one instruction word per instr_valid_in while ready_out is high, and a
// data memory that returns read data in the same cycle that mem_req_out.rd is high
`timescale 1ns/1ns
`include "cpu_ops_params.svh"

// Overview of operation
// - a memory-to-memory move takes a source word 1100 and a destination word 1111, each with a 12-bit address.
// - load_bank_literal writes its literal into bank_select_reg.
// - load_literal_acc puts its literal in the working register in one cycle with flags untouched.
// - store_acc_to_file writes the working register to the addressed file in one cycle with flags untouched.
// - an 8-bit file field reaches any byte of the 256-byte bank chosen by the access bit.
// - access bit 0 picks the access bank, access bit 1 takes the upper address from bank_select_reg.
// - with the extended set on and access bit 0, fields up to 5fh are offsets from the index pointer.
// - the multiplies place the unsigned 16-bit product in product_high and product_low, flags untouched.
// - negate_file writes the two's complement back and updates negative, overflow, carry, digit carry and zero.
// - push puts the next address on the return stack in one cycle.
// - relative_subroutine_call pushes the return address, adds twice the signed offset and idles one cycle.
// - the software reset returns every register and flag to its reset value in one cycle.
// - return_with_literal loads the literal into W, pops the stack top into the counter and takes two cycles.
module cpu_move_mul_stack_ops (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_b_in,
    input  wire logic                 instr_valid_in,
    input  wire logic [15:0]          instr_in,
    input  wire logic [7:0]           mem_rdata_in,
    input  wire logic                 ext_set_en_in,
    input  wire logic [11:0]          index_ptr_in,
    input  wire logic                 irq_entry_in,
    input  wire logic                 irq_is_high_in,
    output logic                      ready_out,
    output cpu_ops_pkg::mem_req_s     mem_req_out,
    output logic [20:0]               pc_out,
    output logic [7:0]                w_out,
    output logic [3:0]                bank_select_reg_out,
    output logic [4:0]                flags_out,
    output logic [7:0]                product_high_out,
    output logic [7:0]                product_low_out,
    output logic                      soft_reset_out,
    output logic                      high_prio_irq_enable_set_out,
    output logic                      low_prio_irq_enable_set_out
);
    import cpu_ops_pkg::*;

    core_state_s s_reg;
    core_state_s s_next;
    logic        push_req;
    logic        pop_req;
    logic        stack_clear;
    logic [20:0] push_data;
    logic [20:0] stack_top;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic core_state_s reset_state();
        core_state_s r;
        r          = '0;
        r.phase    = PH_FETCH;
        r.w        = `RST_BYTE;
        r.bank_select_reg      = `RST_BANK;
        r.flags    = `RST_FLAGS;
        r.pc       = `RST_PC;
        r.ready    = 1'b1;
        return r;
    endfunction

    function automatic logic [11:0] file_addr(input logic [15:0] ins, input logic [3:0] bank_select_reg,
                                              input logic ext, input logic [11:0] idx);
        logic [7:0] f;
        f = ins[7:0];
        if (ins[`FLD_ACCESS_BIT]) begin
            return {bank_select_reg, f};
        end else if (ext && f <= `INDEXED_LIMIT) begin
            return idx + {4'h0, f};
        end else if (f < `ACCESS_SPLIT) begin
            return {`ACCESS_LOW_BANK, f};
        end else begin
            return {`ACCESS_HIGH_BANK, f};
        end
    endfunction

    function automatic logic [15:0] product(input logic [7:0] a, input logic [7:0] b);
        return {8'h00, a} * {8'h00, b};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0]  neg;
        logic [15:0] prod;
        logic [20:0] pc_inc;
        neg         = '0;
        prod        = '0;
        pc_inc      = s_reg.pc + `PC_STEP;
        s_next      = s_reg;
        s_next.mem.rd      = 1'b0;
        s_next.mem.wr      = 1'b0;
        s_next.soft_reset  = 1'b0;
        s_next.gie_hi_set  = 1'b0;
        s_next.gie_lo_set  = 1'b0;
        push_req    = 1'b0;
        pop_req     = 1'b0;
        stack_clear = 1'b0;
        push_data   = pc_inc;
        if (irq_entry_in) begin
            s_next.sh_w     = s_reg.w;
            s_next.sh_flags = s_reg.flags;
            s_next.sh_bsr   = s_reg.bank_select_reg;
        end
        case (s_reg.phase)
            PH_FETCH: begin
                if (instr_valid_in) begin
                    s_next.instr = instr_in;
                    s_next.pc    = pc_inc;
                    casez (instr_in)
                        `OPC_MEM_MOVE_SRC: begin
                            s_next.mem.addr = instr_in[11:0];
                            s_next.mem.rd   = 1'b1;
                            s_next.phase    = PH_MOVE_LATCH;
                        end
                        `OPC_LOAD_BANK_LIT: begin
                            s_next.bank_select_reg = instr_in[3:0];
                        end
                        `OPC_LOAD_LIT_ACC: begin
                            s_next.w = instr_in[7:0];
                        end
                        `OPC_STORE_ACC: begin
                            s_next.mem.addr  = file_addr(instr_in, s_reg.bank_select_reg, ext_set_en_in, index_ptr_in);
                            s_next.mem.wr    = 1'b1;
                            s_next.mem.wdata = s_reg.w;
                        end
                        `OPC_MUL_LIT_ACC: begin
                            prod           = product(s_reg.w, instr_in[7:0]);
                            s_next.prod_hi = prod[15:8];
                            s_next.prod_lo = prod[7:0];
                        end
                        `OPC_MUL_FILE_ACC, `OPC_NEGATE_FILE: begin
                            s_next.mem.addr = file_addr(instr_in, s_reg.bank_select_reg, ext_set_en_in, index_ptr_in);
                            s_next.mem.rd   = 1'b1;
                            s_next.phase    = PH_OPERAND;
                        end
                        `OPC_PUSH: begin
                            push_req = 1'b1;
                        end
                        `OPC_POP: begin
                            pop_req = 1'b1;
                        end
                        `OPC_REL_CALL: begin
                            push_req     = 1'b1;
                            s_next.pc    = pc_inc + {{9{instr_in[`FLD_OFFSET_MSB]}}, instr_in[10:0], 1'b0};
                            s_next.phase = PH_IDLE_CYCLE;
                        end
                        `OPC_SOFT_RESET: begin
                            s_next            = reset_state();
                            s_next.soft_reset = 1'b1;
                            stack_clear       = 1'b1;
                        end
                        `OPC_RETURN_IRQ, `OPC_RETURN_SUB: begin
                            s_next.pc    = stack_top;
                            pop_req      = 1'b1;
                            s_next.phase = PH_IDLE_CYCLE;
                            if (instr_in[`FLD_SHADOW_BIT]) begin
                                s_next.w     = s_reg.sh_w;
                                s_next.flags = s_reg.sh_flags;
                                s_next.bank_select_reg   = s_reg.sh_bsr;
                            end
                            if (!instr_in[`FLD_RETURN_KIND]) begin
                                s_next.gie_hi_set = irq_is_high_in;
                                s_next.gie_lo_set = !irq_is_high_in;
                            end
                        end
                        `OPC_RETURN_LIT: begin
                            s_next.w     = instr_in[7:0];
                            s_next.pc    = stack_top;
                            pop_req      = 1'b1;
                            s_next.phase = PH_IDLE_CYCLE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            PH_OPERAND: begin
                s_next.phase = PH_FETCH;
                if (s_reg.instr[15:12] == `NIB_NEGATE) begin
                    neg              = 8'h00 - mem_rdata_in;
                    s_next.mem.wr    = 1'b1;
                    s_next.mem.wdata = neg;
                    s_next.flags[`FLAG_NEG]         = neg[7];
                    s_next.flags[`FLAG_OVERFLOW]    = (mem_rdata_in == 8'h80);
                    s_next.flags[`FLAG_ZERO]        = (neg == 8'h00);
                    s_next.flags[`FLAG_DIGIT_CARRY] = (mem_rdata_in[3:0] == 4'h0);
                    s_next.flags[`FLAG_CARRY]       = (mem_rdata_in == 8'h00);
                end else begin
                    prod           = product(s_reg.w, mem_rdata_in);
                    s_next.prod_hi = prod[15:8];
                    s_next.prod_lo = prod[7:0];
                end
            end
            PH_MOVE_LATCH: begin
                s_next.hold  = mem_rdata_in;
                s_next.phase = PH_MOVE_DEST;
            end
            PH_MOVE_DEST: begin
                if (instr_valid_in) begin
                    s_next.pc    = pc_inc;
                    s_next.phase = PH_FETCH;
                    if (instr_in[15:12] == `NIB_MEM_MOVE_DST) begin
                        s_next.mem.addr  = instr_in[11:0];
                        s_next.mem.wr    = 1'b1;
                        s_next.mem.wdata = s_reg.hold;
                    end
                end
            end
            PH_IDLE_CYCLE: begin
                s_next.phase = PH_FETCH;
            end
            default: begin
                s_next.phase = PH_FETCH;
            end
        endcase
        s_next.ready = (s_next.phase == PH_FETCH) || (s_next.phase == PH_MOVE_DEST);
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg <= reset_state();
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // return stack

    return_stack u_stack (
        .core_clk_in  (core_clk_in),
        .rst_b_in     (rst_b_in),
        .clear_in     (stack_clear),
        .push_in      (push_req),
        .pop_in       (pop_req),
        .push_data_in (push_data),
        .top_out      (stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign ready_out                    = s_reg.ready;
    assign mem_req_out                  = s_reg.mem;
    assign pc_out                       = s_reg.pc;
    assign w_out                        = s_reg.w;
    assign bank_select_reg_out          = s_reg.bank_select_reg;
    assign flags_out                    = s_reg.flags;
    assign product_high_out             = s_reg.prod_hi;
    assign product_low_out              = s_reg.prod_lo;
    assign soft_reset_out               = s_reg.soft_reset;
    assign high_prio_irq_enable_set_out = s_reg.gie_hi_set;
    assign low_prio_irq_enable_set_out  = s_reg.gie_lo_set;

endmodule

/* File: cpu_move_mul_stack_ops_props.sv */
// concurrent checks on the decoder slice ports
// assumes it is bound to cpu_move_mul_stack_ops, one clock domain
`timescale 1ns/1ns
module ops_checker (
    input wire logic                  core_clk_in,
    input wire logic                  rst_b_in,
    input wire logic                  instr_valid_in,
    input wire logic [15:0]           instr_in,
    input wire logic                  ext_set_en_in,
    input wire logic [11:0]           index_ptr_in,
    input wire logic                  ready_out,
    input wire cpu_ops_pkg::mem_req_s mem_req_out,
    input wire logic [20:0]           pc_out,
    input wire logic [7:0]            w_out,
    input wire logic [3:0]            bank_select_reg_out,
    input wire logic [4:0]            flags_out,
    input wire logic [7:0]            product_high_out,
    input wire logic [7:0]            product_low_out
);
    import cpu_ops_pkg::*;
    logic       take;
    logic [7:0] fld;
    assign take = instr_valid_in && ready_out;
    assign fld  = instr_in[7:0];
    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    ////////////////////////////////////////
    // one refused cycle, then ready again
    sequence s_stall;
        !ready_out ##1 ready_out;
    endsequence
    property p_lit_acc;
        take && instr_in[15:8] == 8'h0e |=> w_out == $past(fld) && $stable(flags_out);
    endproperty
    a_lit_acc: assert property (p_lit_acc) else $error("w not loaded");
    property p_lit_bank;
        take && instr_in[15:8] == 8'h01 |=> bank_select_reg_out == $past(instr_in[3:0]);
    endproperty
    a_lit_bank: assert property (p_lit_bank) else $error("bank not loaded");
    property p_store;
        take && instr_in[15:9] == 7'h37
            |=> mem_req_out.wr && mem_req_out.wdata == $past(w_out) && $stable(flags_out);
    endproperty
    a_store: assert property (p_store) else $error("store write wrong");
    property p_bank_addr;
        take && instr_in[15:8] == 8'h6f |=> mem_req_out.addr == {$past(bank_select_reg_out), $past(fld)};
    endproperty
    a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
    property p_indexed;
        take && instr_in[15:8] == 8'h6e && ext_set_en_in && fld <= 8'h5f
            |=> mem_req_out.addr == $past(index_ptr_in) + {4'h0, $past(fld)};
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");
    property p_mul;
        take && instr_in[15:8] == 8'h0d
            |=> {product_high_out, product_low_out} == $past(w_out) * $past(fld) && $stable(flags_out);
    endproperty
    a_mul: assert property (p_mul) else $error("product wrong");
    property p_call;
        take && instr_in[15:11] == 5'h1b
            |=> pc_out == $past(pc_out) + 21'h2 + {{9{$past(instr_in[10])}}, $past(instr_in[10:0]), 1'b0} ##0 s_stall;
    endproperty
    a_call: assert property (p_call) else $error("call target wrong");
    property p_move;
        take && instr_in[15:12] == 4'hc
            |=> mem_req_out.rd && mem_req_out.addr == $past(instr_in[11:0]) ##0 s_stall;
    endproperty
    a_move: assert property (p_move) else $error("move source read wrong");
endmodule

bind cpu_move_mul_stack_ops ops_checker chk_i (
    .core_clk_in, .rst_b_in, .instr_valid_in, .instr_in, .ext_set_en_in, .index_ptr_in, .ready_out,
    .mem_req_out, .pc_out, .w_out, .bank_select_reg_out, .flags_out, .product_high_out, .product_low_out
);

/* File: cpu_ops_params.svh */
// constants for the move, multiply and stack slice of the instruction decoder
// assumes 16-bit instruction words, a 12-bit data space and a 21-bit program counter
`ifndef CPU_OPS_PARAMS_SVH
`define CPU_OPS_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// instruction patterns
`define OPC_MEM_MOVE_SRC     16'b1100_????_????_????
`define OPC_MEM_MOVE_DST     16'b1111_????_????_????
`define OPC_LOAD_BANK_LIT    16'b0000_0001_????_????
`define OPC_LOAD_LIT_ACC     16'b0000_1110_????_????
`define OPC_STORE_ACC        16'b0110_111?_????_????
`define OPC_MUL_LIT_ACC      16'b0000_1101_????_????
`define OPC_MUL_FILE_ACC     16'b0000_001?_????_????
`define OPC_NEGATE_FILE      16'b0110_110?_????_????
`define OPC_IDLE_INSTR       16'h0000
`define OPC_PUSH             16'h0005
`define OPC_POP              16'h0006
`define OPC_REL_CALL         16'b1101_1???_????_????
`define OPC_SOFT_RESET       16'h00ff
`define OPC_RETURN_IRQ       16'b0000_0000_0001_000?
`define OPC_RETURN_SUB       16'b0000_0000_0001_001?
`define OPC_RETURN_LIT       16'b0000_1100_????_????
`define NIB_MEM_MOVE_DST     4'hf
`define NIB_NEGATE           4'h6

////////////////////////////////////////////////////////////////////////////////
// instruction fields
`define FLD_ACCESS_BIT       8
`define FLD_SHADOW_BIT       0
`define FLD_RETURN_KIND      1
`define FLD_OFFSET_MSB       10

////////////////////////////////////////////////////////////////////////////////
// addressing
`define INDEXED_LIMIT        8'h5f
`define ACCESS_SPLIT         8'h60
`define ACCESS_LOW_BANK      4'h0
`define ACCESS_HIGH_BANK     4'hf
`define PC_STEP              21'h000002

////////////////////////////////////////////////////////////////////////////////
// flag positions, reset values and return stack size
`define FLAG_NEG             4
`define FLAG_OVERFLOW        3
`define FLAG_ZERO            2
`define FLAG_DIGIT_CARRY     1
`define FLAG_CARRY           0
`define RST_BYTE             8'h00
`define RST_BANK             4'h0
`define RST_FLAGS            5'h00
`define RST_PC               21'h000000
`define STACK_DEPTH          31
`define STACK_PTR_W          5

`endif

/* File: cpu_ops_pkg.sv */
// types shared by the decoder and its return stack
// assumes cpu_ops_params.svh is on the include path
package cpu_ops_pkg;

    typedef enum logic [2:0] {
        PH_FETCH      = 3'b000,
        PH_OPERAND    = 3'b001,
        PH_MOVE_LATCH = 3'b010,
        PH_MOVE_DEST  = 3'b011,
        PH_IDLE_CYCLE = 3'b100
    } phase_e;

    typedef struct packed {
        logic [11:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } mem_req_s;

    typedef struct packed {
        phase_e      phase;
        logic [15:0] instr;
        logic [7:0]  hold;
        logic [7:0]  w;
        logic [3:0]  bank_select_reg;
        logic [4:0]  flags;
        logic [7:0]  prod_hi;
        logic [7:0]  prod_lo;
        logic [20:0] pc;
        logic [7:0]  sh_w;
        logic [4:0]  sh_flags;
        logic [3:0]  sh_bsr;
        mem_req_s    mem;
        logic        ready;
        logic        soft_reset;
        logic        gie_hi_set;
        logic        gie_lo_set;
    } core_state_s;

    typedef struct packed {
        logic [4:0]  ptr;
    } stack_state_s;

endpackage

/* File: return_stack.sv */
// return stack holding program counter values
// assumes push and pop are never asked for in the same cycle
`timescale 1ns/1ns
`include "cpu_ops_params.svh"

module return_stack (
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        clear_in,
    input  wire logic        push_in,
    input  wire logic        pop_in,
    input  wire logic [20:0] push_data_in,
    output logic      [20:0] top_out
);
    import cpu_ops_pkg::*;

    logic [20:0]  entry_mem [`STACK_DEPTH];
    stack_state_s s_reg;
    stack_state_s s_next;

    always_comb begin
        s_next = s_reg;
        if (clear_in) begin
            s_next.ptr = '0;
        end else if (push_in && s_reg.ptr != 5'(`STACK_DEPTH)) begin
            s_next.ptr = s_reg.ptr + 5'h01;
        end else if (pop_in && s_reg.ptr != '0) begin
            s_next.ptr = s_reg.ptr - 5'h01;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // previous top moves one level down simply by the pointer advancing
    always_ff @(posedge core_clk_in) begin
        if (push_in && !clear_in && s_reg.ptr != 5'(`STACK_DEPTH)) begin
            entry_mem[s_reg.ptr] <= push_data_in;
        end
    end

    assign top_out = (s_reg.ptr == '0) ? `RST_PC : entry_mem[s_reg.ptr - 5'h01];

endmodule

/* File: tb_top.sv */
// self-checking bench for the move, multiply and stack decoder slice
// assumes the design and its checker are compiled before it
`timescale 1ns/1ns
module tb_top;
    import cpu_ops_pkg::*;
    typedef struct packed {
        logic [15:0] op;
        logic [7:0]  w;
        logic [3:0]  bank_select_reg;
        logic [15:0] prod;
    } row_s;
    logic        core_clk_in, rst_b_in, instr_valid_in, ext_set_en_in, irq_entry_in, irq_is_high_in;
    logic [15:0] instr_in;
    logic [7:0]  mem_rdata_in, w_out, product_high_out, product_low_out;
    logic [11:0] index_ptr_in;
    logic        ready_out, soft_reset_out, high_prio_irq_enable_set_out, low_prio_irq_enable_set_out;
    mem_req_s    mem_req_out;
    logic [20:0] pc_out, exp_pc, top_a;
    logic [3:0]  bank_select_reg_out;
    logic [4:0]  flags_out;
    int          errors, cmp_count;
    row_s        rows [10] = '{{16'h0e5a, 8'h5a, 4'h0, 16'h0000}, {16'h0105, 8'h5a, 4'h5, 16'h0000},
        {16'h01fa, 8'h5a, 4'ha, 16'h0000}, {16'h0ee2, 8'he2, 4'ha, 16'h0000}, {16'h0dc4, 8'he2, 4'ha, 16'had08},
        {16'h0000, 8'he2, 4'ha, 16'had08}, {16'h0dff, 8'he2, 4'ha, 16'he11e}, {16'h0eff, 8'hff, 4'ha, 16'he11e},
        {16'h0dff, 8'hff, 4'ha, 16'hfe01}, {16'h0d00, 8'hff, 4'ha, 16'h0000}};
    logic [28:0] st [7] = '{{16'h6f34, 1'b0, 12'ha34}, {16'h6e80, 1'b0, 12'hf80}, {16'h6e10, 1'b0, 12'h010},
        {16'h6e10, 1'b1, 12'h400}, {16'h6e5f, 1'b1, 12'h44f}, {16'h6e60, 1'b1, 12'hf60}, {16'h6f05, 1'b1, 12'ha05}};
    logic [20:0] ng [4] = '{{8'h3a, 8'hc6, 5'h10}, {8'h80, 8'h80, 5'h1a}, {8'h00, 8'h00, 5'h07},
        {8'h01, 8'hff, 5'h10}};
    logic [10:0] offs [3] = '{11'h3ff, 11'h400, 11'h7fd};

    cpu_move_mul_stack_ops uut (
        .core_clk_in, .rst_b_in, .instr_valid_in, .instr_in, .mem_rdata_in, .ext_set_en_in, .index_ptr_in,
        .irq_entry_in, .irq_is_high_in, .ready_out, .mem_req_out, .pc_out, .w_out, .bank_select_reg_out,
        .flags_out, .product_high_out, .product_low_out, .soft_reset_out, .high_prio_irq_enable_set_out,
        .low_prio_irq_enable_set_out
    );
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // valid stays up so that words can follow back to back
    task automatic issue(input logic [15:0] op);
        instr_in = op;
        instr_valid_in = 1'b1;
        exp_pc = exp_pc + 21'h2;
        @(negedge core_clk_in);
    endtask
    task automatic settle;
        instr_valid_in = 1'b0;
        @(negedge core_clk_in);
    endtask
    task automatic note(input string s);
        $display("test %s done, mismatches %0d", s, errors);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    // about twenty-seven times the length of the planned run
    initial begin
        #20000;
        errors++;
        give_verdict();
    end
    initial begin
        {rst_b_in, instr_valid_in, ext_set_en_in, irq_entry_in, irq_is_high_in} = 5'h0;
        instr_in = 16'h0000;
        mem_rdata_in = 8'h00;
        index_ptr_in = 12'h3f0;
        exp_pc = 21'h0;
        repeat (2) @(negedge core_clk_in);
        chk("reset", {ready_out, pc_out, w_out, bank_select_reg_out, flags_out}, {1'b1, 38'h0});
        rst_b_in = 1'b1;
        foreach (rows[i]) begin
            issue(rows[i].op);
            chk("row", {w_out, bank_select_reg_out, rows[i].op, flags_out, pc_out},
                {rows[i].w, rows[i].bank_select_reg, rows[i].op, 5'h0, exp_pc});
            chk("product", {product_high_out, product_low_out}, rows[i].prod);
        end
        note("table");
        foreach (st[i]) begin
            ext_set_en_in = st[i][12];
            issue(st[i][28:13]);
            chk("store", {mem_req_out.wr, mem_req_out.wdata, mem_req_out.addr}, {1'b1, 8'hff, st[i][11:0]});
        end
        ext_set_en_in = 1'b0;
        settle;
        note("store");
        foreach (ng[i]) begin
            issue(16'h6d34);
            chk("negate read", {mem_req_out.rd, ready_out, mem_req_out.addr}, {2'b10, 12'ha34});
            mem_rdata_in = ng[i][20:13];
            settle;
            mem_rdata_in = ~ng[i][20:13];
            chk("negate", {mem_req_out.wr, mem_req_out.wdata, flags_out}, {1'b1, ng[i][12:0]});
        end
        issue(16'h0334);
        mem_rdata_in = 8'hb5;
        settle;
        mem_rdata_in = 8'h4a;
        repeat (2) @(negedge core_clk_in);
        chk("file product", {product_high_out, product_low_out}, 16'hb44b);
        issue(16'hc123);
        mem_rdata_in = 8'h55;
        settle;
        mem_rdata_in = 8'haa;
        issue(16'hf456);
        chk("move", {mem_req_out.wr, mem_req_out.addr, mem_req_out.wdata}, {1'b1, 12'h456, 8'h55});
        settle;
        note("memory");
        issue(16'h0005);
        top_a = exp_pc;
        issue(16'h0005);
        issue(16'h0006);
        chk("push pop", {pc_out, ready_out}, {exp_pc, 1'b1});
        issue(16'h0012);
        exp_pc = top_a;
        chk("return", {pc_out, ready_out}, {exp_pc, 1'b0});
        settle;
        foreach (offs[i]) begin
            issue({5'h1b, offs[i]});
            top_a = exp_pc;
            exp_pc = exp_pc + {{9{offs[i][10]}}, offs[i], 1'b0};
            chk("call", {pc_out, ready_out}, {exp_pc, 1'b0});
            settle;
            issue(16'h0012);
            exp_pc = top_a;
            chk("call return", pc_out, exp_pc);
            settle;
        end
        issue(16'h0005);
        top_a = exp_pc;
        issue(16'h0c77);
        exp_pc = top_a;
        chk("literal return", {pc_out, w_out, ready_out}, {exp_pc, 8'h77, 1'b0});
        settle;
        irq_entry_in = 1'b1;
        @(negedge core_clk_in);
        irq_entry_in = 1'b0;
        for (int s = 1; s >= 0; s--) begin
            irq_is_high_in = s[0];
            issue(16'h0005);
            top_a = exp_pc;
            issue(16'h0e33);
            issue({15'h0008, s[0]});
            exp_pc = top_a;
            chk("irq return", {pc_out, w_out, high_prio_irq_enable_set_out, low_prio_irq_enable_set_out},
                {exp_pc, s[0] ? 8'h77 : 8'h33, s[0], ~s[0]});
            settle;
        end
        note("stack");
        issue(16'h0005);
        issue(16'h00ff);
        exp_pc = 21'h0;
        chk("soft reset", {soft_reset_out, pc_out, w_out, bank_select_reg_out}, {1'b1, 33'h0});
        chk("soft reset flags", {flags_out, product_high_out, product_low_out}, 21'h0);
        issue(16'h0012);
        exp_pc = 21'h0;
        chk("stack cleared", pc_out, exp_pc);
        settle;
        note("soft reset");
        // reset in mid-run, with a loaded working register
        issue(16'h0e5a);
        rst_b_in = 1'b0;
        @(negedge core_clk_in);
        chk("mid reset", {ready_out, pc_out, w_out, bank_select_reg_out, flags_out}, {1'b1, 38'h0});
        rst_b_in = 1'b1;
        exp_pc = 21'h0;
        issue(16'h0e3c);
        chk("after reset", {w_out, pc_out}, {8'h3c, exp_pc});
        settle;
        note("mid reset");
        give_verdict();
    end
endmodule
